// ===== tetc_pkg_tick.sv
// Shared constants and types, and the microsecond time base of the block.
package tetc_pkg;
  // Clock rate and the microsecond tick derived from it.
  localparam int CLK_HZ      = 25_000_000;
  localparam int US_PER_S    = 1_000_000;
  localparam int TICK_CYCLES = CLK_HZ / US_PER_S;
  localparam int TMR_W       = 24;
  localparam int CNT_W       = 32;
  localparam int NUM_LINES   = 4;
  localparam int NUM_IN      = 3;
  // Register byte offsets.
  localparam logic [4:0] OFS_TMR_DELAY  = 5'h00;
  localparam logic [4:0] OFS_TMR_LENGTH = 5'h04;
  localparam logic [4:0] OFS_LINE_SRC   = 5'h08;
  localparam logic [4:0] OFS_CNT_CFG    = 5'h0c;
  localparam logic [4:0] OFS_CNT_CMD    = 5'h10;
  localparam logic [4:0] OFS_CNT_VALUE  = 5'h14;
  localparam logic [4:0] OFS_STATUS     = 5'h18;
  // Field positions.
  localparam int CFG_EVT_LSB   = 0;
  localparam int CFG_CLR_LSB   = 4;
  localparam int CFG_INFO_BIT  = 12;
  localparam int CMD_CLR_BIT   = 0;
  localparam int LINE_USER_LSB = 16;
  localparam int ST_PHASE_LSB  = 1;
  localparam int ST_ACQ_BIT    = 3;
  // Reset values and the unit step of each counter.
  localparam logic [TMR_W-1:0] RST_TMR = 24'h000000;
  localparam logic [CNT_W-1:0] RST_CNT = 32'h00000000;
  localparam logic [CNT_W-1:0] ONE_CNT = 32'h00000001;
  localparam logic [TMR_W-1:0] ONE_TMR = 24'h000001;
  typedef enum logic [1:0] {
    TETC_PH_IDLE  = 2'b00,
    TETC_PH_DELAY = 2'b01,
    TETC_PH_PULSE = 2'b10
  } tetc_phase_e;
  typedef enum logic [1:0] {
    TETC_EV_FRAME_TRIG = 2'b00,
    TETC_EV_BURST_TRIG = 2'b01,
    TETC_EV_FRAME_BEG  = 2'b10
  } tetc_evt_sel_e;
  typedef enum logic [2:0] {
    TETC_CLR_NONE  = 3'b000,
    TETC_CLR_SW    = 3'b001,
    TETC_CLR_INPUT_LINE_ZERO = 3'b010,
    TETC_CLR_INPUT_LINE_TWO = 3'b011,
    TETC_CLR_INPUT_LINE_THREE = 3'b100
  } tetc_clr_sel_e;
  typedef enum logic [1:0] {
    TETC_LS_LOW   = 2'b00,
    TETC_LS_TIMER = 2'b01,
    TETC_LS_USER  = 2'b10
  } tetc_line_src_e;
  // Avalon-MM request and acquisition events travel as groups.
  typedef struct packed {
    logic        read;
    logic        write;
    logic [4:0]  address;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } tetc_avm_req_s;
  typedef struct packed {
    logic exposure_begin;
    logic frame_trigger;
    logic burst_trigger;
    logic frame_begin;
  } tetc_evt_s;
endpackage

// Free running microsecond tick that restarts on request so that a timed
// phase begins on a whole microsecond boundary.
module tetc_us_tick #(
  parameter int TICKS = tetc_pkg::TICK_CYCLES
) (
  input  wire logic sys_clk_in,
  input  wire logic rst_n_in,
  input  wire logic restart_in,
  output logic      tick_out
);
  typedef struct packed {
    logic [7:0] cnt;
    logic       tick;
  } tetc_tick_s;
  localparam logic [7:0] LAST = 8'(TICKS - 1);
  tetc_tick_s q;
  tetc_tick_s d;

  // The tick fires once every TICKS cycles after the last restart.
  always_comb
  begin
    d = q;
    d.tick = 1'b0;
    if (restart_in)
    begin
      d.cnt = 8'h00;
    end
    else if (q.cnt == LAST)
    begin
      d.cnt  = 8'h00;
      d.tick = 1'b1;
    end
    else
    begin
      d.cnt = q.cnt + 8'h01;
    end
  end

  // State register.
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign tick_out = q.tick;
endmodule // tetc_us_tick

// ===== tetc_top.sv
// Event timer and event counter with an Avalon-MM register slave.
// Summary of operation
// (R1) There is one event timer and it starts only on an exposure begin.
// (R2) The timer output rises after the delay, falls after the pulse length, and the count clears as it falls.
// (R3) The start delay takes any whole number of microseconds from 0 to 16777215.
// (R4) The pulse length takes any whole number of microseconds from 0 to 16777215.
// (R5) Exposure begins during a running cycle are ignored until the pulse has ended.
// (R6) When acquisition stops the timer is cleared and its output falls at once.
// (R7) Every output line can select the timer output as its source.
// (R8) After a start the output stays low for the delay, then high for the length.
// (R9) One event counter counts one chosen source: frame trigger, burst trigger or frame begin.
// (R10) The counter starts from zero after reset and after every clear.
// (R11) Trigger events are counted after filtering and before any trigger delay.
// (R12) With frame info enabled the current count is attached to each frame.
// (R13) The clear source is none, software, input line zero, two or three.
// (R14) A line clear acts only on a rising edge, the only edge offered.
// (R15) The count survives an acquisition stop; only a selected clear or reset zeroes it.
// (R16) Software may send the clear command and the counter then clears; the code clears only while the clear source is software.
// (R17) The counter is 32 bits wide and wraps to zero.
module tetc_top #(
  parameter int NL    = tetc_pkg::NUM_LINES,
  parameter int TICKS = tetc_pkg::TICK_CYCLES
) (
  input  wire logic                      sys_clk_in,
  input  wire logic                      rst_n_in,
  input  wire tetc_pkg::tetc_avm_req_s   avs_req_in,
  output logic                           avs_waitrequest_out,
  output logic [31:0]                    avs_readdata_out,
  input  wire tetc_pkg::tetc_evt_s       acq_events_in,
  input  wire logic                      acquisition_active_in,
  input  wire logic                      input_line_zero_in,
  input  wire logic                      input_line_two_in,
  input  wire logic                      input_line_three_in,
  output logic                           timer_output_active_out,
  output logic [NL-1:0]                  io_line_out,
  output logic [tetc_pkg::CNT_W-1:0]     frame_info_count_out,
  output logic                           frame_info_valid_out
);
  localparam int TW = tetc_pkg::TMR_W;
  localparam int CW = tetc_pkg::CNT_W;
  localparam int NI = tetc_pkg::NUM_IN;

  typedef struct packed {
    logic                   waitreq;
    logic [31:0]            rdata;
    logic [TW-1:0]          delay;
    logic [TW-1:0]          length;
    logic [NL-1:0][1:0]     line_src;
    logic [NL-1:0]          user_lvl;
    logic [1:0]             evt_sel;
    logic [2:0]             clr_sel;
    logic                   info_en;
    tetc_pkg::tetc_phase_e  phase;
    logic [TW-1:0]          tcount;
    logic                   tout;
    logic [NL-1:0]          lines;
    logic [CW-1:0]          count;
    logic [NI-1:0]          sync1;
    logic [NI-1:0]          sync2;
    logic [NI-1:0]          prev;
    logic [CW-1:0]          info_cnt;
    logic                   info_vld;
  } tetc_state_s;

  tetc_state_s   q;
  tetc_state_s   d;
  logic          tick;
  logic          start;
  logic [NL-1:0] line_next;

  // A start is taken only from the idle phase with acquisition running.
  assign start = acquisition_active_in
               & acq_events_in.exposure_begin           // [R1]
               & (q.phase == tetc_pkg::TETC_PH_IDLE);    // [R5]

  // Restarting the time base aligns the delay to the start event, so a
  // delay of N microseconds is N times TICKS cycles plus one cycle long.
  tetc_us_tick #(
    .TICKS      (TICKS)
  ) u_tick (
    .sys_clk_in (sys_clk_in),
    .rst_n_in   (rst_n_in),
    .restart_in (start),
    .tick_out   (tick)
  );

  // Per-line source selection feeds the output flops.
  for (genvar i = 0; i < NL; i++)
  begin : g_line
    always_comb
    begin
      unique case (q.line_src[i])
        tetc_pkg::TETC_LS_TIMER: line_next[i] = d.tout;  // [R7]
        tetc_pkg::TETC_LS_USER:  line_next[i] = q.user_lvl[i];
        default:                 line_next[i] = 1'b0;
      endcase
    end
  end

  // Byte-lane merge for register writes.
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
      begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Next-state logic for bus slave, timer and counter.
  always_comb
  begin
    logic [31:0]   wval;
    logic [31:0]   rval;
    logic          wr_take;
    logic          cnt_inc;
    logic          cnt_clr;
    logic          sw_clr;
    logic [NI-1:0] rise;
    logic [TW-1:0] tinc;
    d = q;
    wval = 32'h00000000;
    rval = 32'h00000000;
    sw_clr = 1'b0;
    wr_take = 1'b0;
    cnt_inc = 1'b0;
    cnt_clr = 1'b0;
    rise = '0;
    tinc = q.tcount + tetc_pkg::ONE_TMR;
    d.info_vld = 1'b0;

    // Input lines pass two flops; edges are seen on the second.
    d.sync1 = {input_line_three_in, input_line_two_in, input_line_zero_in};
    d.sync2 = q.sync1;
    d.prev  = q.sync2;
    rise    = q.sync2 & ~q.prev;                        // [R14]

    // One wait cycle per access: waitrequest drops for a single cycle and
    // the access completes at the edge that ends it.
    wr_take = avs_req_in.write & ~q.waitreq;
    if ((avs_req_in.read | avs_req_in.write) & q.waitreq)
    begin
      d.waitreq = 1'b0;
    end
    else
    begin
      d.waitreq = 1'b1;
    end

    // Read multiplexer; unmapped offsets read as zero.
    unique case (avs_req_in.address)
      tetc_pkg::OFS_TMR_DELAY:  rval = 32'(q.delay);
      tetc_pkg::OFS_TMR_LENGTH: rval = 32'(q.length);
      tetc_pkg::OFS_LINE_SRC:
      begin
        rval = 32'(q.line_src);
        rval[tetc_pkg::LINE_USER_LSB +: NL] = q.user_lvl;
      end
      tetc_pkg::OFS_CNT_CFG:
      begin
        rval[tetc_pkg::CFG_EVT_LSB +: 2] = q.evt_sel;
        rval[tetc_pkg::CFG_CLR_LSB +: 3] = q.clr_sel;
        rval[tetc_pkg::CFG_INFO_BIT]     = q.info_en;
      end
      tetc_pkg::OFS_CNT_VALUE:  rval = q.count;
      tetc_pkg::OFS_STATUS:
      begin
        rval[0] = q.tout;
        rval[tetc_pkg::ST_PHASE_LSB +: 2] = q.phase;
        rval[tetc_pkg::ST_ACQ_BIT] = acquisition_active_in;
      end
      default:                  rval = 32'h00000000;
    endcase
    if (avs_req_in.read & q.waitreq)
    begin
      d.rdata = rval;
    end

    // Register writes honour byte enables.
    if (wr_take)
    begin
      unique case (avs_req_in.address)
        tetc_pkg::OFS_TMR_DELAY:
        begin
          wval    = be_merge(32'(q.delay), avs_req_in.writedata,
                             avs_req_in.byteenable);
          d.delay = wval[TW-1:0];                        // [R3]
        end
        tetc_pkg::OFS_TMR_LENGTH:
        begin
          wval     = be_merge(32'(q.length), avs_req_in.writedata,
                              avs_req_in.byteenable);
          d.length = wval[TW-1:0];                       // [R4]
        end
        tetc_pkg::OFS_LINE_SRC:
        begin
          wval = be_merge(rval, avs_req_in.writedata,
                          avs_req_in.byteenable);
          d.line_src = wval[2*NL-1:0];                   // [R7]
          d.user_lvl = wval[tetc_pkg::LINE_USER_LSB +: NL];
        end
        tetc_pkg::OFS_CNT_CFG:
        begin
          wval = be_merge(rval, avs_req_in.writedata,
                          avs_req_in.byteenable);
          // Codes outside the offered choices are refused.
          if (wval[tetc_pkg::CFG_EVT_LSB +: 2] <= 2'(tetc_pkg::TETC_EV_FRAME_BEG))
          begin
            d.evt_sel = wval[tetc_pkg::CFG_EVT_LSB +: 2]; // [R9]
          end
          if (wval[tetc_pkg::CFG_CLR_LSB +: 3] <= 3'(tetc_pkg::TETC_CLR_INPUT_LINE_THREE))
          begin
            d.clr_sel = wval[tetc_pkg::CFG_CLR_LSB +: 3]; // [R13]
          end
          d.info_en = wval[tetc_pkg::CFG_INFO_BIT];
        end
        tetc_pkg::OFS_CNT_CMD:
        begin
          sw_clr = avs_req_in.byteenable[0]
                 & avs_req_in.writedata[tetc_pkg::CMD_CLR_BIT]; // [R16]
        end
        default:
        begin
          wval = 32'h00000000;
        end
      endcase
    end

    // Timer: low for the delay, high for the length, then re-armed.
    unique case (q.phase)
      tetc_pkg::TETC_PH_IDLE:
      begin
        if (start)
        begin
          d.tcount = tetc_pkg::RST_TMR;
          if (q.delay != tetc_pkg::RST_TMR)
          begin
            d.phase = tetc_pkg::TETC_PH_DELAY;           // [R8]
          end
          else if (q.length != tetc_pkg::RST_TMR)
          begin
            d.phase = tetc_pkg::TETC_PH_PULSE;
            d.tout  = 1'b1;                              // [R2]
          end
        end
      end
      tetc_pkg::TETC_PH_DELAY:
      begin
        if (tick)
        begin
          d.tcount = tinc;
          if (tinc >= q.delay)
          begin
            d.tcount = tetc_pkg::RST_TMR;
            if (q.length != tetc_pkg::RST_TMR)
            begin
              d.phase = tetc_pkg::TETC_PH_PULSE;         // [R8]
              d.tout  = 1'b1;                            // [R2]
            end
            else
            begin
              d.phase = tetc_pkg::TETC_PH_IDLE;
            end
          end
        end
      end
      tetc_pkg::TETC_PH_PULSE:
      begin
        if (tick)
        begin
          d.tcount = tinc;
          if (tinc >= q.length)
          begin
            // Count clears with the falling output; only now re-armed.
            d.tcount = tetc_pkg::RST_TMR;                // [R2]
            d.tout   = 1'b0;
            d.phase  = tetc_pkg::TETC_PH_IDLE;           // [R5]
          end
        end
      end
      default:
      begin
        d.phase = tetc_pkg::TETC_PH_IDLE;
      end
    endcase

    // Stopping acquisition abandons any cycle in progress at once.
    if (!acquisition_active_in)
    begin
      d.phase  = tetc_pkg::TETC_PH_IDLE;                 // [R6]
      d.tcount = tetc_pkg::RST_TMR;
      d.tout   = 1'b0;
    end
    d.lines = line_next;

    // Counter source; trigger inputs are the filtered, undelayed ones.
    unique case (q.evt_sel)
      tetc_pkg::TETC_EV_FRAME_TRIG: cnt_inc = acq_events_in.frame_trigger;
      tetc_pkg::TETC_EV_BURST_TRIG: cnt_inc = acq_events_in.burst_trigger;
      tetc_pkg::TETC_EV_FRAME_BEG:  cnt_inc = acq_events_in.frame_begin;
      default:                      cnt_inc = 1'b0;
    endcase                                              // [R9] [R11]

    // Clear source selection.
    unique case (q.clr_sel)
      tetc_pkg::TETC_CLR_SW:    cnt_clr = sw_clr;        // [R16]
      tetc_pkg::TETC_CLR_INPUT_LINE_ZERO: cnt_clr = rise[0];       // [R14]
      tetc_pkg::TETC_CLR_INPUT_LINE_TWO: cnt_clr = rise[1];
      tetc_pkg::TETC_CLR_INPUT_LINE_THREE: cnt_clr = rise[2];
      default:                  cnt_clr = 1'b0;          // [R13]
    endcase

    // An event in the clear cycle still counts, so it is never lost. The
    // count ignores acquisition state and simply wraps past all ones.
    d.count = (cnt_clr ? tetc_pkg::RST_CNT : q.count)    // [R10] [R15]
            + (cnt_inc ? tetc_pkg::ONE_CNT : tetc_pkg::RST_CNT); // [R17]

    // Frame info carries the count as it stands after this frame begin.
    if (q.info_en & acq_events_in.frame_begin)
    begin
      d.info_cnt = d.count;                              // [R12]
      d.info_vld = 1'b1;
    end
  end

  // State register; the counter starts from zero after reset.
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      q         <= '0;
      q.waitreq <= 1'b1;
      q.count   <= tetc_pkg::RST_CNT;                    // [R10]
      q.phase   <= tetc_pkg::TETC_PH_IDLE;
    end
    else
    begin
      q <= d;
    end
  end

  // Every output is a flop of the state register.
  assign avs_waitrequest_out     = q.waitreq;
  assign avs_readdata_out        = q.rdata;
  assign timer_output_active_out = q.tout;
  assign io_line_out             = q.lines;
  assign frame_info_count_out    = q.info_cnt;
  assign frame_info_valid_out    = q.info_vld;
endmodule // tetc_top

// ===== tetc_top_properties.sv
// Checker of the bus handshake, timer output and frame info ports.
module tetc_top_properties (
  input wire logic                       sys_clk_in,
  input wire logic                       rst_n_in,
  input wire tetc_pkg::tetc_avm_req_s    avs_req_in,
  input wire logic                       avs_waitrequest_out,
  input wire logic [31:0]                avs_readdata_out,
  input wire tetc_pkg::tetc_evt_s        acq_events_in,
  input wire logic                       acquisition_active_in,
  input wire logic                       timer_output_active_out,
  input wire logic [tetc_pkg::CNT_W-1:0] frame_info_count_out,
  input wire logic                       frame_info_valid_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic req;
  // Either strobe counts as a pending request.
  assign req = avs_req_in.read || avs_req_in.write;
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  // Bus: one wait state, then exactly one ready cycle.
  wait_state_a: assert property (req && avs_waitrequest_out |=> !avs_waitrequest_out) else $error("no answer after one wait state");
  ready_once_a: assert property (!avs_waitrequest_out || !req |=> avs_waitrequest_out) else $error("ready held too long");
  ready_cause_a: assert property ($fell(avs_waitrequest_out) |-> $past(req)) else $error("ready without request");
  rdata_hold_a: assert property ($changed(avs_readdata_out) |-> !avs_waitrequest_out && $past(avs_req_in.read)) else $error("read data moved outside a read");
  // Timer output is tied to acquisition running.
  acq_stop_a: assert property (!acquisition_active_in |=> !timer_output_active_out) else $error("timer high after stop");
  rise_acq_a: assert property ($rose(timer_output_active_out) |-> $past(acquisition_active_in)) else $error("timer rose while stopped");
  // Frame info only moves with a frame begin.
  info_cause_a: assert property (frame_info_valid_out |-> $past(acq_events_in.frame_begin)) else $error("frame info without frame");
  info_hold_a: assert property (!frame_info_valid_out |-> $stable(frame_info_count_out)) else $error("frame info count moved");
  cover property ($rose(timer_output_active_out));
  cover property (frame_info_valid_out);
  cover property ($fell(avs_waitrequest_out) && avs_req_in.read);
endmodule // tetc_top_properties

bind tetc_top tetc_top_properties u_props (
  .sys_clk_in              (sys_clk_in),
  .rst_n_in                (rst_n_in),
  .avs_req_in              (avs_req_in),
  .avs_waitrequest_out     (avs_waitrequest_out),
  .avs_readdata_out        (avs_readdata_out),
  .acq_events_in           (acq_events_in),
  .acquisition_active_in   (acquisition_active_in),
  .timer_output_active_out (timer_output_active_out),
  .frame_info_count_out    (frame_info_count_out),
  .frame_info_valid_out    (frame_info_valid_out)
);

// ===== tetc_far_model.sv
// Camera core model: acquisition events, acquisition state and input pins.
module tetc_far_model (
  input  wire logic          sys_clk_in,
  output tetc_pkg::tetc_evt_s events_out,
  output logic               acq_on_out,
  output logic [2:0]         pins_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Quiet start: no events, acquisition off, pins low.
  initial
  begin
    events_out = '0;
    acq_on_out = 1'b0;
    pins_out = 3'h0;
  end
  // Triggers arrive already filtered and ahead of any trigger delay.
  task automatic fire(input tetc_pkg::tetc_evt_s ev);
    @(posedge sys_clk_in);
    events_out <= ev;
    @(posedge sys_clk_in);
    events_out <= '0;
  endtask
  // Acquisition level changes on a clock edge, as the core would.
  task automatic set_acq(input logic v);
    @(posedge sys_clk_in);
    acq_on_out <= v;
  endtask
  // Pins are asynchronous at the block but change on an edge here.
  task automatic set_pin(input int i, input logic v);
    @(posedge sys_clk_in);
    pins_out[i] <= v;
  endtask
endmodule // tetc_far_model

// ===== tetc_top_test.sv
// Self-checking bench for the event timer and event counter.
module tetc_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int T = 2;
  localparam int D = 2;
  localparam int L = 3;
  logic                    sys_clk_in;
  logic                    rst_n_in;
  tetc_pkg::tetc_avm_req_s req;
  tetc_pkg::tetc_evt_s     ev;
  logic                    wt;
  logic [31:0]             rd;
  logic                    acq;
  logic [2:0]              pins;
  logic                    tmr;
  logic [3:0]              lines;
  logic [31:0]             fic;
  logic                    fiv;
  int                      num_errors = 0;
  int                      checks = 0;
  logic [3:0]              be = 4'hf;
  // Ordinary register rows: address, write value, expected read back.
  logic [4:0]  ra [5] = '{5'h00, 5'h04, 5'h00, 5'h0c, 5'h0c};
  logic [31:0] rw [5] = '{32'h0, 32'h00ffffff, 32'hffffffff,
                          32'h00001012, 32'h00000053};
  logic [31:0] rx [5] = '{32'h0, 32'h00ffffff, 32'h00ffffff,
                          32'h00001012, 32'h00000012};
  tetc_top #(.TICKS(T)) DUT (
    .sys_clk_in              (sys_clk_in),
    .rst_n_in                (rst_n_in),
    .avs_req_in              (req),
    .avs_waitrequest_out     (wt),
    .avs_readdata_out        (rd),
    .acq_events_in           (ev),
    .acquisition_active_in   (acq),
    .input_line_zero_in      (pins[0]),
    .input_line_two_in       (pins[1]),
    .input_line_three_in     (pins[2]),
    .timer_output_active_out (tmr),
    .io_line_out             (lines),
    .frame_info_count_out    (fic),
    .frame_info_valid_out    (fiv)
  );
  tetc_far_model u_far (
    .sys_clk_in (sys_clk_in),
    .events_out (ev),
    .acq_on_out (acq),
    .pins_out   (pins)
  );
  // 25 MHz clock.
  initial
  begin
    sys_clk_in = 1'b0;
    forever #20 sys_clk_in = ~sys_clk_in;
  end
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One Avalon access; the request holds until waitrequest is seen low.
  // No cycle limit here: a slave that never answers is left to the watchdog.
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    req <= '{read: !w, write: w, address: a, byteenable: be,
             writedata: d};
    do
    begin
      @(posedge sys_clk_in);
    end
    while (wt !== 1'b0);
    q = rd;
    req <= '0;
    @(posedge sys_clk_in);
  endtask
  // Count edges until the timer output shows v, giving up at lim.
  task automatic lvl(input logic v, input int lim, output int n);
    n = 0;
    do
    begin
      @(posedge sys_clk_in);
      n++;
    end
    while (tmr !== v && n < lim);
  endtask
  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Watchdog sized well above the few hundred cycles the tests need.
  initial
  begin
    repeat (20000) @(posedge sys_clk_in);
    num_errors++;
    end_sim();
  end
  initial
  begin
    logic [31:0] q;
    int n;
    rst_n_in = 1'b0;
    req = '0;
    repeat (4) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    @(posedge sys_clk_in);
    chk("waitrequest", 32'h1, wt);
    bus(0, tetc_pkg::OFS_CNT_VALUE, 32'h0, q);
    chk("count", 32'h0, q);
    $display("Test reset done");
    for (int i = 0; i < 5; i++)
    begin
      bus(1, ra[i], rw[i], q);
      bus(0, ra[i], 32'h0, q);
      chk("register", rx[i], q);
    end
    bus(1, 5'h1c, 32'h12345678, q);
    bus(0, 5'h1c, 32'h0, q);
    chk("unmapped", 32'h0, q);
    // Only the enabled byte lane of a write may change.
    be = 4'h2;
    bus(1, tetc_pkg::OFS_TMR_LENGTH, 32'h0000aa55, q);
    be = 4'hf;
    bus(0, tetc_pkg::OFS_TMR_LENGTH, 32'h0, q);
    chk("byte lanes", 32'h00ffaaff, q);
    $display("Test registers done");
    // Line 1 takes the timer, line 3 a high user level; a second exposure
    // lands mid-pulse.
    bus(1, tetc_pkg::OFS_TMR_DELAY, D, q);
    bus(1, tetc_pkg::OFS_TMR_LENGTH, L, q);
    bus(1, tetc_pkg::OFS_LINE_SRC, 32'h00080084, q);
    u_far.set_acq(1'b1);
    u_far.fire(4'h8);
    lvl(1'b1, 100, n);
    // The rise is registered once more and seen one edge after it lands.
    chk("delay cycles", D * T + 2, n);
    chk("line source", 32'ha, lines);
    u_far.fire(4'h8);
    lvl(1'b0, 100, n);
    chk("pulse cycles", L * T - 2, n);
    lvl(1'b1, (D + L) * T + 4, n);
    chk("no rearm", (D + L) * T + 4, n);
    u_far.fire(4'h8);
    lvl(1'b1, 100, n);
    u_far.set_acq(1'b0);
    lvl(1'b0, 100, n);
    chk("stop cycles", 32'h2, n);
    $display("Test timer done");
    // Each source selected in turn while all three fire together; acquisition is stopped meanwhile.
    for (int s = 0; s < 3; s++)
    begin
      bus(1, tetc_pkg::OFS_CNT_CFG, 32'(s) | 32'h10, q);
      bus(1, tetc_pkg::OFS_CNT_CMD, 32'h1, q);
      u_far.fire(4'h7);
      u_far.fire(4'h7);
      bus(0, tetc_pkg::OFS_CNT_VALUE, 32'h0, q);
      chk("count", 32'h2, q);
    end
    // A clear command without its byte lane enabled is not a command.
    be = 4'he;
    bus(1, tetc_pkg::OFS_CNT_CMD, 32'h1, q);
    be = 4'hf;
    bus(0, tetc_pkg::OFS_CNT_VALUE, 32'h0, q);
    chk("lane kept", 32'h2, q);
    bus(1, tetc_pkg::OFS_CNT_CFG, 32'h1002, q);
    bus(1, tetc_pkg::OFS_CNT_CMD, 32'h1, q);
    u_far.fire(4'h1);
    @(posedge sys_clk_in);
    chk("info valid", 32'h1, fiv);
    chk("info count", 32'h3, fic);
    $display("Test counter done");
    // Line clears: only the selected pin, only on its rising edge.
    for (int k = 0; k < 3; k++)
    begin
      bus(1, tetc_pkg::OFS_CNT_CFG, 32'(k + 2) << 4, q);
      u_far.fire(4'h4);
      u_far.set_pin((k + 1) % 3, 1'b1);
      repeat (6) @(posedge sys_clk_in);
      bus(0, tetc_pkg::OFS_CNT_VALUE, 32'h0, q);
      chk("unselected kept", (k == 0) ? 32'h4 : 32'h2, q);
      u_far.set_pin((k + 1) % 3, 1'b0);
      u_far.set_pin(k, 1'b1);
      repeat (6) @(posedge sys_clk_in);
      bus(0, tetc_pkg::OFS_CNT_VALUE, 32'h0, q);
      chk("line clear", 32'h0, q);
      u_far.fire(4'h4);
      u_far.set_pin(k, 1'b0);
      repeat (6) @(posedge sys_clk_in);
      bus(0, tetc_pkg::OFS_CNT_VALUE, 32'h0, q);
      chk("falling kept", 32'h1, q);
    end
    $display("Test line clear done");
    // A second reset mid-run returns the count to zero.
    rst_n_in <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    @(posedge sys_clk_in);
    bus(0, tetc_pkg::OFS_CNT_VALUE, 32'h0, q);
    chk("reset count", 32'h0, q);
    $display("Test second reset done");
    end_sim();
  end
endmodule // tetc_top_test
